// *** i2crg_bus_model.sv ***
`default_nettype none
// ==========================================
// Remote bus party: toggles the bus clock inside frames, plus one last toggle up to 32 ns after a frame ends.
module i2crg_bus_model (
  // Frame control from the bench.
  input  wire logic frame,
  // Bus clock wire, pulled up when released.
  output var  logic scl
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    forever begin
      wait (frame === 1'b1);
      #13;
      while (frame === 1'b1) begin
        #32 scl = ~scl;
      end
      scl = 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** i2crg_pkg.sv ***
`default_nettype none
package i2crg_pkg;
  // ==========================================
  // Register offsets.
  localparam logic [7:0] OFS_CLR_ABORT  = 8'h54;
  localparam logic [7:0] OFS_CLR_RXDONE = 8'h58;
  localparam logic [7:0] OFS_CLR_ACT    = 8'h5C;
  localparam logic [7:0] OFS_CLR_STOP   = 8'h60;
  localparam logic [7:0] OFS_CLR_START  = 8'h64;
  localparam logic [7:0] OFS_CLR_GCALL  = 8'h68;
  localparam logic [7:0] OFS_ENABLE     = 8'h6C;
  localparam logic [7:0] OFS_STATUS     = 8'h70;
  localparam logic [7:0] OFS_TXLEVEL    = 8'h74;
  localparam logic [7:0] OFS_ABORT_CAUSE = 8'h80;
  localparam logic [7:0] OFS_RAW_STATUS = 8'h90;
  // ==========================================
  // Raw interrupt status bit positions.
  localparam int RAW_RXFULL = 2;
  localparam int RAW_TXEMPTY = 4;
  localparam int RAW_ABORT  = 6;
  localparam int RAW_RXDONE = 7;
  localparam int RAW_ACT    = 8;
  localparam int RAW_STOP   = 9;
  localparam int RAW_START  = 10;
  localparam int RAW_GCALL  = 11;
  localparam int RAW_WIDTH  = 12;
  // ==========================================
  // Field positions, widths and reset values.
  localparam int CAUSE_WIDTH = 16;
  localparam int CAUSE_STARTBYTE = 9;
  localparam int STATUS_WIDTH = 7;
  localparam logic [6:0] STATUS_RESET = 7'h06;
  localparam logic [11:0] RAW_RESET = 12'h000;
  localparam logic ENABLE_RESET = 1'h0;
  localparam int ENABLE_DELAY = 2;
  // ==========================================
  // Signals from the serial core, same clock.
  typedef struct packed {
    logic rx_done;
    logic stop_seen;
    logic start_seen;
    logic general_call;
    logic startbyte_cause;
    logic slave_bulk_abort;
    logic tx_pop;
    logic controller_fsm_busy;
    logic target_fsm_busy;
    logic rx_full;
    logic rx_nonempty;
    logic rx_threshold;
  } i2crg_core_type;
  // Controls towards the serial core.
  typedef struct packed {
    logic internal_enable;
    logic tx_flush;
    logic rx_flush;
    logic rx_nack_request;
  } i2crg_ctrl_type;
endpackage
`default_nettype wire

// *** i2crg_regs.sv ***
// Decided for this implementation: the APB register port.
`default_nettype none
// Behaviour
// - Abort-clear read clears raw abort bit, cause register, releases TX FIFO.
// - Start-byte cause bit clears one cycle then resets if cause persists.
// - While raw abort set, TX FIFO stays flushed and refuses writes.
// - Receive-done clear read clears raw bit 7.
// - Activity clear read clears bit only when neither controller nor target is busy.
// - Activity bit self-clears when disabled and quiet; clear read returns bit 8.
// - Stop-detect clear read clears raw bit 9.
// - Start-detect clear read clears raw bit 10.
// - General-call clear read clears raw bit 11.
// - Activity, TX-empty, RX-full are hardware cleared; others software cleared.
// - Enable bit 0 enables; zero disables and flushes both FIFOs; resets 0.
// - After disable, interrupt bits except RX-full stay until state machines are idle.
// - Disabled while sending: finish transfer, discard remaining TX data.
// - Disabled while receiving: stop after current byte, do not acknowledge.
// - With asynchronous clocks, enable changes act two cycles later.
// - Disable sets status bits 1,2 and clears bits 3,4.
// - Status 5,6 drop at idle when disabled; status raises no interrupt.
// - Status 6 target busy, 5 controller busy, 0 is their OR.
// - Status 4 RX FIFO full, 3 RX FIFO non-empty; reset zero.
// - Status 2 TX FIFO empty, 1 TX FIFO not full; reset one.
// - TX level counts entries, up on push, down on pop, resets zero.
// - TX level clears on disable, transmit abort or bulk abort.
module i2crg_regs
  import i2crg_pkg::*;
#(
  parameter int TX_DEPTH    = 8,
  parameter int TX_LVL_W    = 4,
  parameter int TX_THRESH   = 0,
  parameter bit ASYNC_CLOCK = 1'b1
) (
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // APB slave.
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output logic                        pready,
  output var  logic                   pslverr,
  // Serial core side.
  input  wire i2crg_core_type         core,
  input  wire logic [CAUSE_WIDTH-1:0] abort_set,
  input  wire logic                   tx_push_valid,
  output logic                        tx_push_ready,
  output i2crg_ctrl_type              ctrl,
  // Bus clock pin.
  input  wire logic                   scl_in
);

  // ==========================================
  // APB decode.
  logic                   ctrl_en;
  logic                   internal_enable;
  logic [RAW_WIDTH-1:0]   raw;
  logic [CAUSE_WIDTH-1:0] cause;
  logic [TX_LVL_W-1:0]    level;
  logic [31:0]            rd_word;
  logic                   scl_meta;
  logic                   scl_sync;
  logic                   scl_prev;
  logic                   sb_cleared;

  wire setup  = psel & ~penable;
  wire acc    = psel & penable;
  wire rd_acc = acc & ~pwrite;
  wire wr_en  = acc & pwrite & (paddr == OFS_ENABLE);
  wire hit_cla = paddr == OFS_CLR_ABORT;
  wire hit_crd = paddr == OFS_CLR_RXDONE;
  wire hit_cac = paddr == OFS_CLR_ACT;
  wire hit_cst = paddr == OFS_CLR_STOP;
  wire hit_csa = paddr == OFS_CLR_START;
  wire hit_cgc = paddr == OFS_CLR_GCALL;
  wire hit_en  = paddr == OFS_ENABLE;
  wire hit_sta = paddr == OFS_STATUS;
  wire hit_lvl = paddr == OFS_TXLEVEL;
  wire hit_cau = paddr == OFS_ABORT_CAUSE;
  wire hit_raw = paddr == OFS_RAW_STATUS;
  wire mapped  = hit_cla | hit_crd | hit_cac | hit_cst | hit_csa
               | hit_cgc | hit_en | hit_sta | hit_lvl | hit_cau
               | hit_raw;

  // ==========================================
  // Core state and status word.
  wire busy_any = core.controller_fsm_busy | core.target_fsm_busy;
  wire idle_off = ~internal_enable & ~busy_any;
  wire scl_edge = scl_sync ^ scl_prev;
  wire abort_now = |abort_set;
  wire level_clr = ~internal_enable | raw[RAW_ABORT] | abort_now
                 | core.slave_bulk_abort;
  wire tx_full = level >= TX_LVL_W'(TX_DEPTH);
  wire push_ok = tx_push_valid & tx_push_ready;
  wire pop_ok  = core.tx_pop & (level != '0);
  wire [STATUS_WIDTH-1:0] status = {
    core.target_fsm_busy,
    core.controller_fsm_busy,
    core.rx_full & internal_enable,
    core.rx_nonempty & internal_enable,
    level == '0,
    ~tx_full,
    busy_any
  };

  // ==========================================
  // Read-to-clear strobes; a raw bit only clears if it read as one, the cause register on any read.
  wire clr_abort = rd_acc & hit_cla & prdata[0];
  wire clr_cause = rd_acc & hit_cla;
  wire clr_rxd   = rd_acc & hit_crd & prdata[0];
  wire clr_act   = rd_acc & hit_cac & prdata[0]
                 & ~busy_any;
  wire clr_stop  = rd_acc & hit_cst & prdata[0];
  wire clr_start = rd_acc & hit_csa & prdata[0];
  wire clr_gc    = rd_acc & hit_cgc & prdata[0];

  // ==========================================
  // Interrupt bits: hardware set wins over software clear.
  wire [RAW_WIDTH-1:0] hw_set = {
    core.general_call, core.start_seen, core.stop_seen,
    1'b0, core.rx_done, abort_now, 6'h00};
  wire [RAW_WIDTH-1:0] sw_clr = {
    clr_gc, clr_start, clr_stop, 1'b0, clr_rxd, clr_abort,
    6'h00};
  wire act_next = scl_edge | busy_any
                | (raw[RAW_ACT] & ~clr_act & ~idle_off);
  wire txe_next = (level <= TX_LVL_W'(TX_THRESH))
                & (internal_enable | busy_any);
  wire rxf_next = core.rx_threshold & internal_enable;

  genvar gi;
  generate
    for (gi = RAW_ABORT; gi < RAW_WIDTH; gi++) begin : g_raw
      if (gi != RAW_ACT) begin : g_sw
        always_ff @(posedge mclk or negedge nrst) begin
          if (!nrst) begin
            raw[gi] <= RAW_RESET[gi];
          end else begin
            raw[gi] <= hw_set[gi]
                     | (raw[gi] & ~sw_clr[gi] & ~idle_off);
          end
        end
      end
    end
    for (gi = 0; gi < RAW_ABORT; gi++) begin : g_hw
      if (gi == RAW_TXEMPTY || gi == RAW_RXFULL) begin : g_on
        always_ff @(posedge mclk or negedge nrst) begin
          if (!nrst) begin
            raw[gi] <= RAW_RESET[gi];
          end else begin
            raw[gi] <= (gi == RAW_TXEMPTY) ? txe_next : rxf_next;
          end
        end
      end else begin : g_off
        assign raw[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      raw[RAW_ACT] <= RAW_RESET[RAW_ACT];
    end else begin
      raw[RAW_ACT] <= act_next;
    end
  end

  // ==========================================
  // Abort cause register.
  generate
    for (gi = 0; gi < CAUSE_WIDTH; gi++) begin : g_cause
      if (gi == CAUSE_STARTBYTE) begin : g_sb
        always_ff @(posedge mclk or negedge nrst) begin
          if (!nrst) begin
            cause[gi] <= 1'b0;
          end else if (clr_cause) begin
            cause[gi] <= 1'b0;
          end else begin
            cause[gi] <= cause[gi] | abort_set[gi]
                       | (sb_cleared & core.startbyte_cause);
          end
        end
      end else begin : g_plain
        always_ff @(posedge mclk or negedge nrst) begin
          if (!nrst) begin
            cause[gi] <= 1'b0;
          end else begin
            cause[gi] <= abort_set[gi]
                       | (cause[gi] & ~clr_cause);
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sb_cleared <= 1'b0;
    end else begin
      sb_cleared <= clr_cause & cause[CAUSE_STARTBYTE];
    end
  end

  // ==========================================
  // Enable register and its delayed internal copy.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_en <= ENABLE_RESET;
    end else if (wr_en) begin
      ctrl_en <= pwdata[0];
    end
  end

  generate
    if (ASYNC_CLOCK) begin : g_async
      logic [ENABLE_DELAY-1:0] en_pipe;
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          en_pipe <= '0;
        end else begin
          en_pipe <= {en_pipe[ENABLE_DELAY-2:0], ctrl_en};
        end
      end
      assign internal_enable = en_pipe[ENABLE_DELAY-1];
    end else begin : g_sync
      assign internal_enable = ctrl_en;
    end
  endgenerate

  assign ctrl.internal_enable = internal_enable;
  assign ctrl.tx_flush = ~internal_enable
                       | raw[RAW_ABORT];
  assign ctrl.rx_flush = ~internal_enable;
  assign ctrl.rx_nack_request = ~internal_enable;

  // ==========================================
  // Bus clock pin synchroniser and edge finder.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
    end
  end

  // ==========================================
  // Transmit level counter.
  assign tx_push_ready = internal_enable & ~raw[RAW_ABORT]
                       & ~abort_now & ~tx_full;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      level <= '0;
    end else if (level_clr) begin
      level <= '0;
    end else if (push_ok && !pop_ok) begin
      level <= level + 1'b1;
    end else if (pop_ok && !push_ok) begin
      level <= level - 1'b1;
    end
  end

  // ==========================================
  // Read data, captured in the setup phase.
  assign rd_word =
      hit_cla ? {31'h0, raw[RAW_ABORT]}
    : hit_crd ? {31'h0, raw[RAW_RXDONE]}
    : hit_cac ? {31'h0, raw[RAW_ACT]}
    : hit_cst ? {31'h0, raw[RAW_STOP]}
    : hit_csa ? {31'h0, raw[RAW_START]}
    : hit_cgc ? {31'h0, raw[RAW_GCALL]}
    : hit_en  ? {31'h0, ctrl_en}
    : hit_sta ? {25'h0, status}
    : hit_lvl ? {{(32-TX_LVL_W){1'b0}}, level}
    : hit_cau ? {16'h0, cause}
    : hit_raw ? {20'h0, raw}
    : 32'h0;

  assign pready = penable;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0 : rd_word;
      pslverr <= ~mapped;
    end
  end

  // ==========================================
  // Checks.
  sequence s_clr_read(logic hit);
    rd_acc && hit && prdata[0];
  endsequence

  property p_abort_clear;
    @(posedge mclk) disable iff (!nrst)
    s_clr_read(hit_cla) ##0 !abort_now |=> !raw[RAW_ABORT]
      && cause[CAUSE_WIDTH-1:0] == '0;
  endproperty
  a_abort_clear: assert property (p_abort_clear)
    else $error("abort not cleared by read");

  property p_sb_reassert;
    @(posedge mclk) disable iff (!nrst)
    clr_cause && cause[CAUSE_STARTBYTE] && core.startbyte_cause
      ##1 core.startbyte_cause
      |-> !cause[CAUSE_STARTBYTE] ##1 cause[CAUSE_STARTBYTE];
  endproperty
  a_sb_reassert: assert property (p_sb_reassert)
    else $error("start byte cause not reasserted");

  property p_abort_flush;
    @(posedge mclk) disable iff (!nrst)
    raw[RAW_ABORT] |-> !tx_push_ready ##1 level == '0;
  endproperty
  a_abort_flush: assert property (p_abort_flush)
    else $error("tx fifo not flushed during abort");

  property p_rxdone_clear;
    @(posedge mclk) disable iff (!nrst)
    s_clr_read(hit_crd) ##0 !core.rx_done && internal_enable
      |=> !raw[RAW_RXDONE];
  endproperty
  a_rxdone_clear: assert property (p_rxdone_clear)
    else $error("receive done not cleared");

  property p_act_hold;
    @(posedge mclk) disable iff (!nrst)
    rd_acc && hit_cac && busy_any |=> raw[RAW_ACT];
  endproperty
  a_act_hold: assert property (p_act_hold)
    else $error("activity cleared while busy");

  property p_act_auto;
    @(posedge mclk) disable iff (!nrst)
    idle_off && !scl_edge |=> !raw[RAW_ACT];
  endproperty
  a_act_auto: assert property (p_act_auto)
    else $error("activity not cleared when disabled");

  property p_set_wins;
    @(posedge mclk) disable iff (!nrst)
    core.stop_seen |=> raw[RAW_STOP] [*1] ##0 $past(core.stop_seen);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("stop event lost");

  property p_enable_delay;
    @(posedge mclk) disable iff (!nrst)
    ASYNC_CLOCK && $rose(ctrl_en)
      |-> !internal_enable ##1 !internal_enable ##1 internal_enable;
  endproperty
  a_enable_delay: assert property (p_enable_delay)
    else $error("enable delay not two cycles");

  property p_status_off;
    @(posedge mclk) disable iff (!nrst)
    !internal_enable |-> status[2:1] == 2'b11 || level != '0
      ##0 status[4:3] == 2'b00;
  endproperty
  a_status_off: assert property (p_status_off)
    else $error("status wrong while disabled");

  property p_status_or;
    @(posedge mclk) disable iff (!nrst)
    status[0] == (status[5] | status[6]);
  endproperty
  a_status_or: assert property (p_status_or)
    else $error("activity status not the or");

  property p_level_push;
    @(posedge mclk) disable iff (!nrst)
    push_ok && !pop_ok && !level_clr
      |=> level == $past(level) + 1'b1;
  endproperty
  a_level_push: assert property (p_level_push)
    else $error("tx level did not count push");

  property p_level_clear;
    @(posedge mclk) disable iff (!nrst)
    !internal_enable || core.slave_bulk_abort |=> level == '0;
  endproperty
  a_level_clear: assert property (p_level_clear)
    else $error("tx level not cleared");

endmodule
`default_nettype wire

// *** test_i2crg_regs.sv ***
`default_nettype none
module test_i2crg_regs
  import i2crg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int  TX_DEPTH = 8;
  logic           mclk;
  logic           nrst;
  logic [7:0]     paddr;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  i2crg_core_type core;
  logic [15:0]    abort_set;
  logic           tx_push_valid;
  logic           tx_push_ready;
  i2crg_ctrl_type ctrl;
  logic           scl;
  logic           frame;
  int             failures;
  int             num_checks;
  int             cycles;
  int             seed;
  int             n;
  int             txq[$];
  logic [15:0]    cause;
  logic [31:0]    r;
  logic           e;
  int             ev_idx[4] = '{11, 10, 9, 8};
  int             ev_raw[4] = '{RAW_RXDONE, RAW_STOP, RAW_START, RAW_GCALL};
  logic [7:0]     ev_ofs[4] = '{OFS_CLR_RXDONE, OFS_CLR_STOP,
                                OFS_CLR_START, OFS_CLR_GCALL};
  i2crg_regs i_i2crg_regs (
    .mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core(core),
    .abort_set(abort_set), .tx_push_valid(tx_push_valid),
    .tx_push_ready(tx_push_ready), .ctrl(ctrl), .scl_in(scl)
  );
  i2crg_bus_model i_i2crg_bus_model (.frame(frame), .scl(scl));
  // ==========================================
  // Clock, timeout and shared tasks.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(r, exp);
  endtask
  task automatic rdb(input logic [7:0] a, input int b, input logic exp);
    apb(a, 1'b0, 32'h0);
    check({31'h0, r[b]}, {31'h0, exp});
  endtask
  task automatic push(input int cnt);
    repeat (cnt) begin
      @(posedge mclk);
      tx_push_valid <= 1'b1;
      @(posedge mclk);
      if (tx_push_ready === 1'b1) begin
        txq.push_back(1);
      end
      tx_push_valid <= 1'b0;
    end
  endtask
  task automatic pulse(input int idx);
    @(posedge mclk);
    core[idx] <= 1'b1;
    @(posedge mclk);
    core[idx] <= 1'b0;
  endtask
  // ==========================================
  // Main sequence.
  initial begin
    nrst = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    core = '0;
    abort_set = 16'h0000;
    tx_push_valid = 1'b0;
    frame = 1'b0;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    seed = 32'h30A7;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rdc(OFS_STATUS, 32'h6);
    rdc(OFS_TXLEVEL, 32'h0);
    rdc(OFS_ENABLE, 32'h0);
    for (int k = 0; k < 6; k++) begin
      rdc(OFS_CLR_ABORT + 8'(4 * k), 32'h0);
    end
    rdc(8'h00, 32'h0);
    check({31'h0, e}, 32'h1);
    apb(OFS_STATUS, 1'b1, 32'hFF);
    rdc(OFS_STATUS, 32'h6);
    push(1);
    check(txq.size(), 0);
    apb(OFS_ENABLE, 1'b1, 32'h1);
    @(posedge mclk) #1;
    check({31'h0, ctrl.internal_enable}, 32'h0);
    @(posedge mclk) #1;
    check({31'h0, ctrl.internal_enable}, 32'h1);
    check({31'h0, ctrl.tx_flush}, 32'h0);
    rdc(OFS_ENABLE, 32'h1);
    rdb(OFS_RAW_STATUS, RAW_TXEMPTY, 1'b1);
    n = 1 + ($unsigned($random(seed)) % 7);
    push(n);
    rdc(OFS_TXLEVEL, txq.size());
    rdc(OFS_STATUS, 32'h2);
    rdb(OFS_RAW_STATUS, RAW_TXEMPTY, 1'b0);
    push(TX_DEPTH - n + 1);
    rdc(OFS_TXLEVEL, txq.size());
    rdc(OFS_STATUS, 32'h0);
    pulse(5);
    void'(txq.pop_front());
    rdc(OFS_TXLEVEL, txq.size());
    for (int k = 0; k < 4; k++) begin
      pulse(ev_idx[k]);
      repeat (3) @(posedge mclk);
      rdb(OFS_RAW_STATUS, ev_raw[k], 1'b1);
      rdc(ev_ofs[k], 32'h1);
      rdb(OFS_RAW_STATUS, ev_raw[k], 1'b0);
    end
    core.rx_threshold <= 1'b1;
    rdb(OFS_RAW_STATUS, RAW_RXFULL, 1'b1);
    core.rx_threshold <= 1'b0;
    rdb(OFS_RAW_STATUS, RAW_RXFULL, 1'b0);
    cause = 16'($random(seed)) | 16'h0201;
    core.startbyte_cause <= 1'b1;
    abort_set <= cause;
    @(posedge mclk);
    abort_set <= 16'h0000;
    txq.delete();
    rdc(OFS_TXLEVEL, 32'h0);
    push(1);
    check(txq.size(), 0);
    check({31'h0, ctrl.tx_flush}, 32'h1);
    rdc(OFS_ABORT_CAUSE, {16'h0, cause});
    rdc(OFS_CLR_ABORT, 32'h1);
    rdc(OFS_ABORT_CAUSE, 32'h200);
    rdb(OFS_RAW_STATUS, RAW_ABORT, 1'b0);
    core.startbyte_cause <= 1'b0;
    rdc(OFS_CLR_ABORT, 32'h0);
    rdc(OFS_ABORT_CAUSE, 32'h0);
    push(2);
    rdc(OFS_TXLEVEL, txq.size());
    pulse(6);
    txq.delete();
    rdc(OFS_TXLEVEL, 32'h0);
    frame <= 1'b1;
    core.controller_fsm_busy <= 1'b1;
    repeat (60) @(posedge mclk);
    rdc(OFS_STATUS, 32'h27);
    rdc(OFS_CLR_ACT, 32'h1);
    rdb(OFS_RAW_STATUS, RAW_ACT, 1'b1);
    frame <= 1'b0;
    core.controller_fsm_busy <= 1'b0;
    repeat (10) @(posedge mclk);
    rdc(OFS_CLR_ACT, 32'h1);
    rdb(OFS_RAW_STATUS, RAW_ACT, 1'b0);
    push(3);
    core.target_fsm_busy <= 1'b1;
    core.rx_full <= 1'b1;
    core.rx_nonempty <= 1'b1;
    pulse(10);
    rdc(OFS_STATUS, 32'h5B);
    apb(OFS_ENABLE, 1'b1, 32'h0);
    txq.delete();
    repeat (4) @(posedge mclk);
    rdc(OFS_STATUS, 32'h47);
    rdc(OFS_TXLEVEL, 32'h0);
    rdb(OFS_RAW_STATUS, RAW_STOP, 1'b1);
    check({28'h0, ctrl}, 32'h7);
    core.target_fsm_busy <= 1'b0;
    repeat (4) @(posedge mclk);
    rdc(OFS_STATUS, 32'h6);
    rdb(OFS_RAW_STATUS, RAW_STOP, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
